/* eesp_port.v */
// serial configuration prom command port with autoload after reset
`timescale 1ns/1ps
`default_nettype none
`include "eesp_regs.vh"

module eesp_port #(
    parameter CLK_DIV = `EESP_CLK_DIV
) (
    input wire clk,
    input wire nrst,
    input wire bus_valid,
    input wire bus_write,
    input wire bus_cfg,
    input wire [7:0] bus_index,
    input wire [31:0] bus_wdata,
    output reg bus_trdy_reg,
    output reg bus_stop_reg,
    output reg [31:0] bus_rdata_reg,
    output reg prom_select_reg,
    output reg prom_serial_clock_reg,
    output reg prom_serial_out_reg,
    input wire prom_serial_in,
    output reg autoload_active_reg,
    output reg [15:0] subsys_vendor_reg,
    output reg [15:0] subsys_id_reg,
    output reg [7:0] maximum_latency_field_reg,
    output reg [7:0] min_grant_reg
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_SETUP = 3'h1;
    localparam [2:0] ST_SHIFT = 3'h2;
    localparam [2:0] ST_GAP = 3'h3;
    localparam [2:0] ST_POLL = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers

    wire rst_n;
    wire sin_sync;
    wire tick_fall;
    wire tick_rise;

    eesp_sync #(.W(1)) u_rst_sync (
        .clk(clk),
        .rst_n(nrst),
        .d(1'b1),
        .q(rst_n)
    );

    eesp_sync #(.W(1)) u_sin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(prom_serial_in),
        .q(sin_sync)
    );

    // divider runs free so the serial clock phase is fixed to the bus clock
    eesp_clkdiv #(.DIV(CLK_DIV)) u_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick_fall(tick_fall),
        .tick_rise(tick_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // command decode helpers

    // frames that carry sixteen more clocks after the address
    function f_long;
        input [2:0] op;
        input [1:0] sel;
        begin
            f_long = (op == `EESP_OP_READ) || (op == `EESP_OP_WRITE) ||
                ((op == `EESP_OP_MISC) && (sel == `EESP_MISC_WRITE_ALL));
        end
    endfunction

    // commands that program the array and report ready on the serial line
    function f_waits;
        input [2:0] op;
        input [1:0] sel;
        begin
            f_waits = (op == `EESP_OP_WRITE) || (op == `EESP_OP_ERASE) ||
                ((op == `EESP_OP_MISC) && ((sel == `EESP_MISC_ERASE_ALL) ||
                (sel == `EESP_MISC_WRITE_ALL)));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    reg [2:0] state_reg, state_next;
    reg [4:0] bitcnt_reg, bitcnt_next;
    reg [24:0] frame_reg, frame_next;
    reg [15:0] rxsh_reg, rxsh_next;
    reg long_reg, long_next;
    reg isread_reg, isread_next;
    reg need_ready_reg, need_ready_next;
    reg from_load_reg, from_load_next;
    reg [31:0] cmd_reg, cmd_next;
    reg pending_reg, pending_next;
    reg read_busy_reg, read_busy_next;
    reg [15:0] result_reg, result_next;
    reg [1:0] al_idx_reg, al_idx_next;
    reg load_next;
    reg [15:0] svid_next, sid_next;
    reg [7:0] lat_next, gnt_next;
    reg sel_next, sk_next, so_next;
    reg trdy_next, stop_next;
    reg [31:0] rdata_next;

    wire busy_any = pending_reg || (state_reg != ST_IDLE);
    wire [4:0] total_bits = long_reg ? `EESP_LONG_BITS : `EESP_SHORT_BITS;
    wire [2:0] bus_op = bus_wdata[`EESP_CMD_HI:`EESP_CMD_LO];
    wire [2:0] cmd_op = cmd_reg[`EESP_CMD_HI:`EESP_CMD_LO];
    wire [1:0] cmd_sel = cmd_reg[`EESP_SEL_HI:`EESP_SEL_LO];

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always @* begin
        state_next = state_reg;
        bitcnt_next = bitcnt_reg;
        frame_next = frame_reg;
        rxsh_next = rxsh_reg;
        long_next = long_reg;
        isread_next = isread_reg;
        need_ready_next = need_ready_reg;
        from_load_next = from_load_reg;
        cmd_next = cmd_reg;
        pending_next = pending_reg;
        read_busy_next = read_busy_reg;
        result_next = result_reg;
        al_idx_next = al_idx_reg;
        load_next = autoload_active_reg;
        svid_next = subsys_vendor_reg;
        sid_next = subsys_id_reg;
        lat_next = maximum_latency_field_reg;
        gnt_next = min_grant_reg;
        sel_next = prom_select_reg;
        sk_next = prom_serial_clock_reg;
        so_next = prom_serial_out_reg;
        trdy_next = 1'b0;
        stop_next = 1'b0;
        rdata_next = bus_rdata_reg;

        case (state_reg)
            ST_IDLE: begin
                if (autoload_active_reg) begin
                    // autoload reads words in order, marker first
                    frame_next = {`EESP_OP_READ, 4'h0, al_idx_reg, 16'h0000};
                    long_next = 1'b1;
                    isread_next = 1'b1;
                    need_ready_next = 1'b0;
                    from_load_next = 1'b1;
                    bitcnt_next = 5'd0;
                    state_next = ST_SETUP;
                end else if (pending_reg) begin
                    pending_next = 1'b0;
                    // data field only reaches the wire for long frames
                    frame_next = {cmd_op, cmd_reg[`EESP_ADDR_HI:`EESP_ADDR_LO],
                        (cmd_op == `EESP_OP_READ) ? 16'h0000 :
                        cmd_reg[`EESP_DATA_HI:`EESP_DATA_LO]};
                    long_next = f_long(cmd_op, cmd_sel);
                    isread_next = (cmd_op == `EESP_OP_READ);
                    need_ready_next = f_waits(cmd_op, cmd_sel);
                    from_load_next = 1'b0;
                    bitcnt_next = 5'd0;
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (tick_fall) begin
                    sel_next = 1'b1;
                    sk_next = 1'b0;
                    so_next = frame_reg[24];
                    frame_next = {frame_reg[23:0], 1'b0};
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (tick_rise) begin
                    sk_next = 1'b1;
                    bitcnt_next = bitcnt_reg + 5'd1;
                end else if (tick_fall) begin
                    sk_next = 1'b0;
                    // prom drives each read bit after the rise, taken at the fall
                    if (isread_reg && (bitcnt_reg >= `EESP_READ_FIRST)) begin
                        rxsh_next = {rxsh_reg[14:0], sin_sync};
                    end
                    if (bitcnt_reg == total_bits) begin
                        sel_next = 1'b0;
                        so_next = 1'b0;
                        state_next = ST_GAP;
                    end else begin
                        so_next = frame_reg[24];
                        frame_next = {frame_reg[23:0], 1'b0};
                    end
                end
            end
            ST_GAP: begin
                // select stays low a full serial period between phases
                if (tick_fall) begin
                    if (need_ready_reg) begin
                        sel_next = 1'b1;
                        state_next = ST_POLL;
                    end else begin
                        state_next = ST_IDLE;
                        if (isread_reg) begin
                            result_next = rxsh_reg;
                            if (!from_load_reg) begin
                                read_busy_next = 1'b0;
                            end
                        end
                        if (from_load_reg) begin
                            case (al_idx_reg)
                                `EESP_WORD_MARKER: begin
                                    if (rxsh_reg == `EESP_MARKER) begin
                                        al_idx_next = `EESP_WORD_SVID;
                                    end else begin
                                        load_next = 1'b0;
                                    end
                                end
                                `EESP_WORD_SVID: begin
                                    svid_next = rxsh_reg;
                                    al_idx_next = `EESP_WORD_SID;
                                end
                                `EESP_WORD_SID: begin
                                    sid_next = rxsh_reg;
                                    al_idx_next = `EESP_WORD_LAT;
                                end
                                default: begin
                                    lat_next = rxsh_reg[15:8];
                                    gnt_next = rxsh_reg[7:0];
                                    load_next = 1'b0;
                                end
                            endcase
                        end
                    end
                end
            end
            ST_POLL: begin
                // no timeout; ready taken mid period, once the synced input shows the select
                if (tick_rise && sin_sync) begin
                    sel_next = 1'b0;
                    need_ready_next = 1'b0;
                    state_next = ST_GAP;
                end
            end
            default: begin
                state_next = ST_IDLE;
                sel_next = 1'b0;
                sk_next = 1'b0;
                so_next = 1'b0;
            end
        endcase

        // target path, one answer per request on the following edge
        if (bus_valid) begin
            if (autoload_active_reg) begin
                stop_next = 1'b1;
            end else if (bus_cfg) begin
                trdy_next = 1'b1;
                rdata_next = 32'h00000000;
            end else if (bus_write) begin
                if (bus_index == `EESP_CMD_INDEX) begin
                    if (busy_any) begin
                        stop_next = 1'b1;
                    end else begin
                        cmd_next = {bus_wdata[`EESP_DATA_HI:`EESP_DATA_LO], 7'h00,
                            bus_wdata[`EESP_CMD_HI:`EESP_ADDR_LO]};
                        pending_next = 1'b1;
                        trdy_next = 1'b1;
                        if (bus_op == `EESP_OP_READ) begin
                            read_busy_next = 1'b1;
                        end
                    end
                end else begin
                    // result register and unmapped words ignore writes
                    trdy_next = 1'b1;
                end
            end else begin
                trdy_next = 1'b1;
                case (bus_index)
                    `EESP_CMD_INDEX: rdata_next = cmd_reg;
                    `EESP_RES_INDEX: rdata_next = {read_busy_reg, 15'h0000, result_reg};
                    default: rdata_next = 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bitcnt_reg <= 5'd0;
            frame_reg <= 25'h0000000;
            rxsh_reg <= 16'h0000;
            long_reg <= 1'b0;
            isread_reg <= 1'b0;
            need_ready_reg <= 1'b0;
            from_load_reg <= 1'b0;
            cmd_reg <= 32'h00000000;
            pending_reg <= 1'b0;
            read_busy_reg <= 1'b0;
            result_reg <= 16'h0000;
            al_idx_reg <= `EESP_WORD_MARKER;
            autoload_active_reg <= 1'b1;
            subsys_vendor_reg <= `EESP_SVID_RESET;
            subsys_id_reg <= `EESP_SID_RESET;
            maximum_latency_field_reg <= `EESP_LAT_RESET;
            min_grant_reg <= `EESP_GNT_RESET;
            prom_select_reg <= 1'b0;
            prom_serial_clock_reg <= 1'b0;
            prom_serial_out_reg <= 1'b0;
            bus_trdy_reg <= 1'b0;
            bus_stop_reg <= 1'b0;
            bus_rdata_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            bitcnt_reg <= bitcnt_next;
            frame_reg <= frame_next;
            rxsh_reg <= rxsh_next;
            long_reg <= long_next;
            isread_reg <= isread_next;
            need_ready_reg <= need_ready_next;
            from_load_reg <= from_load_next;
            cmd_reg <= cmd_next;
            pending_reg <= pending_next;
            read_busy_reg <= read_busy_next;
            result_reg <= result_next;
            al_idx_reg <= al_idx_next;
            autoload_active_reg <= load_next;
            subsys_vendor_reg <= svid_next;
            subsys_id_reg <= sid_next;
            maximum_latency_field_reg <= lat_next;
            min_grant_reg <= gnt_next;
            prom_select_reg <= sel_next;
            prom_serial_clock_reg <= sk_next;
            prom_serial_out_reg <= so_next;
            bus_trdy_reg <= trdy_next;
            bus_stop_reg <= stop_next;
            bus_rdata_reg <= rdata_next;
        end
    end

endmodule

`default_nettype wire

/* eesp_regs.vh */
// constants for the serial configuration prom command port
`ifndef EESP_REGS_VH
`define EESP_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register indices on the target path (byte address is four times these)
`define EESP_CMD_INDEX 8'h0c
`define EESP_RES_INDEX 8'h0d

////////////////////////////////////////////////////////////////////////////////
// eeprom_command fields
`define EESP_DATA_HI 31
`define EESP_DATA_LO 16
`define EESP_CMD_HI 8
`define EESP_CMD_LO 6
`define EESP_ADDR_HI 5
`define EESP_ADDR_LO 0
`define EESP_SEL_HI 5
`define EESP_SEL_LO 4

// eeprom_read_result fields
`define EESP_BUSY_BIT 31

////////////////////////////////////////////////////////////////////////////////
// command codes (start bit plus two opcode bits)
`define EESP_OP_READ 3'h6
`define EESP_OP_WRITE 3'h5
`define EESP_OP_ERASE 3'h7
`define EESP_OP_MISC 3'h4

// upper address bits under the misc code
`define EESP_MISC_UNLOCK 2'h3
`define EESP_MISC_LOCK 2'h0
`define EESP_MISC_ERASE_ALL 2'h2
`define EESP_MISC_WRITE_ALL 2'h1

////////////////////////////////////////////////////////////////////////////////
// serial timing and framing
`define EESP_CLK_DIV 36
`define EESP_SHORT_BITS 5'd9
`define EESP_LONG_BITS 5'd25
`define EESP_READ_FIRST 5'd10

////////////////////////////////////////////////////////////////////////////////
// autoload layout and defaults
`define EESP_MARKER 16'ha5a5
`define EESP_WORD_MARKER 2'h0
`define EESP_WORD_SVID 2'h1
`define EESP_WORD_SID 2'h2
`define EESP_WORD_LAT 2'h3
`define EESP_SVID_RESET 16'h0000
`define EESP_SID_RESET 16'h0000
`define EESP_LAT_RESET 8'h00
`define EESP_GNT_RESET 8'h00

`endif

/* eesp_sync.v */
// two flip-flop synchroniser with asynchronous clear
`timescale 1ns/1ps
`default_nettype none

module eesp_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    reg [W-1:0] meta_reg;

    // meta_reg feeds q only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

`default_nettype wire

/* eesp_clkdiv.v */
// free running divider giving fall and rise ticks of the serial clock
`timescale 1ns/1ps
`default_nettype none

module eesp_clkdiv #(
    parameter DIV = 36
) (
    input wire clk,
    input wire rst_n,
    output reg tick_fall,
    output reg tick_rise
);

    localparam [5:0] LAST = DIV - 1;
    localparam [5:0] HALF = DIV / 2;

    reg [5:0] cnt_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 6'h00;
            tick_fall <= 1'b0;
            tick_rise <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg == LAST) ? 6'h00 : cnt_reg + 6'h01;
            tick_fall <= (cnt_reg == 6'h00);
            tick_rise <= (cnt_reg == HALF);
        end
    end

endmodule

`default_nettype wire

/* eesp_prom_model.sv */
// behavioural model of the serial word-organised configuration prom
`timescale 1ns/1ps
`default_nettype none

module eesp_prom_model #(
    parameter int BUSY_CLK = 200
) (
    input wire logic clk,
    input wire logic sel,
    input wire logic sclk,
    input wire logic din,
    output logic dout
);
    logic [15:0] mem [0:63];
    logic [24:0] sh = 25'h0;
    logic [2:0] op = 3'h0;
    logic [5:0] adr = 6'h00;
    logic rd_bit = 1'b0;
    logic tog = 1'b0;
    logic unlocked = 1'b0;
    int n = 0;
    int busy_cnt = 0;

    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 16'hffff;
        mem[0] = 16'ha5a5;
        mem[1] = 16'h1b2c;
        mem[2] = 16'h3d4e;
        mem[3] = 16'h5f60;
    end

    // a released output toggles so a stale level is never mistaken for data
    always @(negedge clk) begin
        tog <= ~tog;
        if (busy_cnt > 0) busy_cnt = busy_cnt - 1;
    end

    always @(posedge sclk) begin
        if (sel) begin
            n = n + 1;
            sh = {sh[23:0], din};
            if (n == 9) begin
                op = sh[8:6];
                adr = sh[5:0];
                rd_bit <= 1'b0;
            end else if (n > 9 && n < 26 && op == 3'h6) begin
                rd_bit <= mem[adr][25 - n];
            end
        end
    end

    always @(negedge sel) begin
        if (n >= 9) begin
            if (op == 3'h4 && adr[5:4] == 2'h3) unlocked = 1'b1;
            if (op == 3'h4 && adr[5:4] == 2'h0) unlocked = 1'b0;
            // locked part ignores program commands and never goes busy
            if (unlocked && op != 3'h6 && !(op == 3'h4 && adr[5] == adr[4])) begin
                for (int i = 0; i < 64; i++)
                    if (op == 3'h4 || i == adr)
                        mem[i] = (op != 3'h5 && (op == 3'h7 || adr[5])) ? 16'hffff : sh[15:0];
                busy_cnt = BUSY_CLK;
            end
        end
        n = 0;
    end

    // selected and not shifting read data: show ready, also after an ignored command
    assign dout = !sel ? tog : (op == 3'h6 && n >= 9) ? rd_bit : (busy_cnt == 0);
endmodule
`default_nettype wire

/* eesp_port_asserts.sv */
// concurrent checks on the prom command port pins
`timescale 1ns/1ps
`default_nettype none

module eesp_port_asserts #(
    parameter CLK_DIV = 36
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic bus_cfg,
    input wire logic [7:0] bus_index,
    input wire logic bus_trdy_reg,
    input wire logic bus_stop_reg,
    input wire logic [31:0] bus_rdata_reg,
    input wire logic prom_select_reg,
    input wire logic prom_serial_clock_reg,
    input wire logic prom_serial_out_reg,
    input wire logic autoload_active_reg
);
    int hi_cnt;
    int lo_cnt;
    logic res_rd_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt <= 0;
            lo_cnt <= 0;
            res_rd_q <= 1'b0;
        end else begin
            hi_cnt <= prom_serial_clock_reg ? hi_cnt + 1 : 0;
            lo_cnt <= (prom_select_reg && !prom_serial_clock_reg) ? lo_cnt + 1 : 0;
            res_rd_q <= bus_valid && !bus_write && !bus_cfg && bus_index == 8'h0d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_answered;
        bus_trdy_reg ^ bus_stop_reg;
    endsequence
    sequence s_retried;
        bus_stop_reg && !bus_trdy_reg;
    endsequence

    a_answer_next: assert property (bus_valid |=> s_answered)
        else $error("request not answered on the next edge");
    a_answer_caused: assert property ((bus_trdy_reg || bus_stop_reg) |-> $past(bus_valid))
        else $error("answer without a request");
    a_boot_retry: assert property (bus_valid && autoload_active_reg |=> s_retried)
        else $error("access during autoload not retried");
    a_busy_retry: assert property (bus_valid && bus_write && !bus_cfg
        && bus_index == 8'h0c && prom_select_reg |=> s_retried)
        else $error("command taken while a frame runs");
    a_sclk_idle: assert property (!prom_select_reg |-> !prom_serial_clock_reg)
        else $error("serial clock high without select");
    a_sclk_high: assert property ($fell(prom_serial_clock_reg) |-> hi_cnt == CLK_DIV / 2)
        else $error("serial clock high phase wrong");
    a_sclk_low: assert property ($rose(prom_serial_clock_reg) |-> lo_cnt == CLK_DIV / 2)
        else $error("serial clock low phase wrong");
    a_out_at_fall: assert property ($changed(prom_serial_out_reg) |-> !prom_serial_clock_reg)
        else $error("serial data moved while clock high");
    a_result_zeros: assert property (bus_trdy_reg && res_rd_q |-> bus_rdata_reg[30:16] == 15'h0000)
        else $error("result middle bits not zero");
endmodule

bind eesp_port eesp_port_asserts #(.CLK_DIV(CLK_DIV)) eesp_port_asserts_inst (
    .clk(clk),
    .nrst(nrst),
    .bus_valid(bus_valid),
    .bus_write(bus_write),
    .bus_cfg(bus_cfg),
    .bus_index(bus_index),
    .bus_trdy_reg(bus_trdy_reg),
    .bus_stop_reg(bus_stop_reg),
    .bus_rdata_reg(bus_rdata_reg),
    .prom_select_reg(prom_select_reg),
    .prom_serial_clock_reg(prom_serial_clock_reg),
    .prom_serial_out_reg(prom_serial_out_reg),
    .autoload_active_reg(autoload_active_reg)
);
`default_nettype wire

/* eesp_port_test.sv */
// self-checking bench for the prom command port
`timescale 1ns/1ps
`default_nettype none

module eesp_port_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic bus_valid = 1'b0;
    logic bus_write = 1'b0;
    logic bus_cfg = 1'b0;
    logic [7:0] bus_index = 8'h00;
    logic [31:0] bus_wdata = 32'h00000000;
    wire bus_trdy_reg, bus_stop_reg, prom_select_reg, prom_serial_clock_reg;
    wire prom_serial_out_reg, prom_serial_in, autoload_active_reg;
    wire [31:0] bus_rdata_reg;
    wire [15:0] subsys_vendor_reg, subsys_id_reg;
    wire [7:0] maximum_latency_field_reg, min_grant_reg;
    int bad_count = 0;
    int n_checks = 0;
    logic stop;
    logic [31:0] rd;

    always #5 clk = ~clk;

    eesp_port #(.CLK_DIV(36)) eesp_port_inst (
        .clk(clk),
        .nrst(nrst),
        .bus_valid(bus_valid),
        .bus_write(bus_write),
        .bus_cfg(bus_cfg),
        .bus_index(bus_index),
        .bus_wdata(bus_wdata),
        .bus_trdy_reg(bus_trdy_reg),
        .bus_stop_reg(bus_stop_reg),
        .bus_rdata_reg(bus_rdata_reg),
        .prom_select_reg(prom_select_reg),
        .prom_serial_clock_reg(prom_serial_clock_reg),
        .prom_serial_out_reg(prom_serial_out_reg),
        .prom_serial_in(prom_serial_in),
        .autoload_active_reg(autoload_active_reg),
        .subsys_vendor_reg(subsys_vendor_reg),
        .subsys_id_reg(subsys_id_reg),
        .maximum_latency_field_reg(maximum_latency_field_reg),
        .min_grant_reg(min_grant_reg)
    );

    eesp_prom_model eesp_prom_model_inst (
        .clk(clk),
        .sel(prom_select_reg),
        .sclk(prom_serial_clock_reg),
        .din(prom_serial_out_reg),
        .dout(prom_serial_in)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one access, answer taken at the following falling edge
    task bus_op(input logic wr, input logic cfg, input logic [7:0] idx, input logic [31:0] wd);
        @(negedge clk);
        bus_valid = 1'b1;
        bus_write = wr;
        bus_cfg = cfg;
        bus_index = idx;
        bus_wdata = wd;
        @(negedge clk);
        bus_valid = 1'b0;
        stop = bus_stop_reg;
        rd = bus_rdata_reg;
        check(bus_trdy_reg ^ bus_stop_reg, 1'b1);
    endtask

    task cmd(input logic [2:0] op, input logic [5:0] a, input logic [15:0] d);
        int i;
        i = 0;
        stop = 1'b1;
        while (stop !== 1'b0 && i < 8000) begin
            bus_op(1'b1, 1'b0, 8'h0c, {d, 7'h00, op, a});
            i++;
        end
        check(stop, 1'b0);
    endtask

    task read_word(input logic [5:0] a, input logic [15:0] exp);
        int i;
        cmd(3'h6, a, 16'h0000);
        bus_op(1'b0, 1'b0, 8'h0d, 32'h0);
        check(rd[31], 1'b1);
        bus_op(1'b1, 1'b0, 8'h0c, 32'h00000180);
        check(stop, 1'b1);
        i = 0;
        rd = 32'h80000000;
        while (rd[31] !== 1'b0 && i < 2000) begin
            bus_op(1'b0, 1'b0, 8'h0d, 32'h0);
            i++;
        end
        check(rd[31:16], 16'h0000);
        check(rd[15:0], exp);
    endtask

    task reset_and_boot;
        int i;
        nrst = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        check(autoload_active_reg, 1'b1);
        bus_op(1'b0, 1'b1, 8'h00, 32'h0);
        check(stop, 1'b1);
        bus_op(1'b1, 1'b0, 8'h0c, 32'h00000180);
        check(stop, 1'b1);
        i = 0;
        while (autoload_active_reg !== 1'b0 && i < 8000) begin
            @(negedge clk);
            i++;
        end
        check(autoload_active_reg, 1'b0);
    endtask

    initial begin
        #600000;
        bad_count++;
        tally_and_finish;
    end

    initial begin
        reset_and_boot;
        check({subsys_vendor_reg, subsys_id_reg}, 32'h1b2c3d4e);
        check(maximum_latency_field_reg, 8'h5f);
        check(min_grant_reg, 8'h60);
        // configuration cycles are answered normally once autoload is over
        bus_op(1'b0, 1'b1, 8'h00, 32'h0);
        check(stop, 1'b0);
        check(rd, 32'h00000000);
        cmd(3'h4, 6'h30, 16'h0000);
        cmd(3'h5, 6'h05, 16'hc3a1);
        bus_op(1'b1, 1'b0, 8'h0c, 32'h00000180);
        check(stop, 1'b1);
        bus_op(1'b0, 1'b0, 8'h0c, 32'h0);
        check(rd, {16'hc3a1, 7'h00, 3'h5, 6'h05});
        read_word(6'h05, 16'hc3a1);
        cmd(3'h7, 6'h05, 16'h0000);
        read_word(6'h05, 16'hffff);
        cmd(3'h4, 6'h10, 16'h0f0f);
        read_word(6'h3f, 16'h0f0f);
        cmd(3'h4, 6'h20, 16'h0000);
        read_word(6'h00, 16'hffff);
        cmd(3'h4, 6'h00, 16'h0000);
        cmd(3'h5, 6'h07, 16'h1234);
        read_word(6'h07, 16'hffff);
        // marker now erased, so the next boot must keep the defaults
        reset_and_boot;
        check({subsys_vendor_reg, subsys_id_reg}, 32'h00000000);
        check({maximum_latency_field_reg, min_grant_reg}, 16'h0000);
        tally_and_finish;
    end
endmodule
`default_nettype wire
